// *** rtl/bridge_pwm_controller.sv ***
// Bridge PWM controller: four outputs A..D in single, half or full mode.
// Assumes commands are one-cycle strobes synchronous to core_clk_i.
//
// Contract
// - Mode 0 single, 1 half bridge, 2 full forward, 3 full reverse.
// - Two-bit polarity sets active level of A/C and B/D pairs.
// - Code 1 makes A and C active high, B and D active low.
// - Single mode setting is a D,C,B,A enable mask.
// - Half mode setting is dead band delay 0 to 127.
// - Eight-bit period sets one full on/off cycle length.
// - Ten-bit duty sets mark time within each cycle.
// - Used pins become outputs automatically on activation.
// - Unused pins keep their general-purpose function.
// - Single uses masked pins, half A and B, full all four.
// - All enabled single outputs carry the same waveform together.
// - Half mode: A carries PWM, B its complement.
// - Non-zero dead band keeps both half outputs inactive for value*4+2 to value*4+5 clocks.
// - Full forward: A active, D modulated, B and C inactive.
// - Full reverse: C active, B modulated, A and D inactive.
// - Duty-only update keeps timer; ignored until activated.
`timescale 1ns/10ps
module bridge_pwm_controller (
    input wire logic core_clk_i, // Core clock, 20 MHz
    input wire logic reset_n_i, // Async reset, active low
    input wire logic start_i, // Strobe: load all and activate
    input wire logic stop_i, // Strobe: off command
    input wire logic duty_load_i, // Strobe: duty-only update
    input wire logic [1:0] mode_i, // Mode code
    input wire logic [1:0] polarity_i, // Polarity code
    input wire logic [7:0] setting_i, // Mask or dead band
    input wire logic [7:0] period_i, // Period value
    input wire logic [9:0] duty_i, // Duty value
    input wire logic [3:0] gpio_out_i, // General-purpose levels D..A
    input wire logic [3:0] gpio_oe_n_i, // General-purpose enables, low=drive
    output logic [3:0] pin_o, // Pin levels D..A
    output logic [3:0] pin_oe_n_o, // Pin enables, low=drive
    output logic [3:0] pwm_owned_o, // Pins held by the PWM
    output logic active_o // Controller running
);
    bridge_pwm_pkg::run_state_t state;
    bridge_pwm_pkg::run_state_t next_state;
    bridge_pwm_pkg::mode_t mode;
    logic [1:0] polarity;
    logic [3:0] mask;
    logic [6:0] dead;
    logic [7:0] period;
    logic [9:0] duty;
    logic [9:0] counter;
    logic [9:0] next_counter;
    logic [1:0] div;
    logic tick;
    logic [3:0] active_lvl;
    logic [3:0] owned;
    logic [3:0] want_active;
    logic [3:0] pin_level;
    logic [3:0] next_pin;
    logic [3:0] next_oe_n;
    dead_band_if db ();

    dead_band u_dead_band (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .db(db)
    );

    wire running = (state == bridge_pwm_pkg::ST_RUN);
    wire mark = running && (counter < duty);
    wire wrap = (counter >= {2'h0, period});

    assign active_lvl[bridge_pwm_pkg::IDX_A] = ~polarity[1];
    assign active_lvl[bridge_pwm_pkg::IDX_C] = ~polarity[1];
    assign active_lvl[bridge_pwm_pkg::IDX_B] = ~polarity[0];
    assign active_lvl[bridge_pwm_pkg::IDX_D] = ~polarity[0];

    always_comb begin
        case (mode)
            bridge_pwm_pkg::MODE_SINGLE: owned = mask;
            bridge_pwm_pkg::MODE_HALF: owned = bridge_pwm_pkg::MASK_HALF;
            bridge_pwm_pkg::MODE_FULL_FWD: owned = bridge_pwm_pkg::MASK_FULL;
            bridge_pwm_pkg::MODE_FULL_REV: owned = bridge_pwm_pkg::MASK_FULL;
            default: owned = bridge_pwm_pkg::MASK_NONE;
        endcase
    end

    always_comb begin
        case (mode)
            bridge_pwm_pkg::MODE_SINGLE: want_active = {4{mark}};
            bridge_pwm_pkg::MODE_HALF:
                want_active = {2'b00, db.lo_ok, db.hi_ok};
            bridge_pwm_pkg::MODE_FULL_FWD:
                want_active = {mark, 1'b0, 1'b0, 1'b1};
            bridge_pwm_pkg::MODE_FULL_REV:
                want_active = {1'b0, 1'b1, mark, 1'b0};
            default: want_active = 4'h0;
        endcase
    end

    assign db.raw = mark;
    assign db.enable = running && (mode == bridge_pwm_pkg::MODE_HALF);
    assign db.tick = tick;
    assign db.delay = dead;

    // Per-pin output selection
    genvar gi;
    generate
        for (gi = 0; gi < bridge_pwm_pkg::OUT_N; gi++) begin : g_pin
            assign pin_level[gi] = want_active[gi] ? active_lvl[gi]
                                                   : ~active_lvl[gi];
            assign next_pin[gi] = (running && owned[gi]) ? pin_level[gi]
                                                         : gpio_out_i[gi];
            assign next_oe_n[gi] = (running && owned[gi]) ? 1'b0
                                                          : gpio_oe_n_i[gi];
        end
    endgenerate

    always_comb begin
        next_state = state;
        case (state)
            bridge_pwm_pkg::ST_IDLE:
                if (start_i && !stop_i) next_state = bridge_pwm_pkg::ST_RUN;
            bridge_pwm_pkg::ST_RUN:
                if (stop_i) next_state = bridge_pwm_pkg::ST_IDLE;
            default: next_state = bridge_pwm_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        if (!running || start_i || wrap) begin
            next_counter = 10'h000;
        end else begin
            next_counter = counter + 10'h001;
        end
    end

    // Instruction-cycle enable for the dead band
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            div <= 2'h0;
            tick <= 1'b0;
        end else begin
            div <= (div == bridge_pwm_pkg::INSTR_DIV_MAX) ? 2'h0 : div + 2'h1;
            tick <= (div == bridge_pwm_pkg::INSTR_DIV_MAX);
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= bridge_pwm_pkg::ST_IDLE;
            counter <= 10'h000;
        end else begin
            state <= next_state;
            counter <= next_counter;
        end
    end

    // Configuration latches on start; setting copied to both mask and dead
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode <= bridge_pwm_pkg::MODE_SINGLE;
            polarity <= 2'h0;
            mask <= 4'h0;
            dead <= 7'h00;
            period <= 8'h00;
        end else if (start_i) begin
            mode <= bridge_pwm_pkg::mode_t'(mode_i);
            polarity <= polarity_i;
            mask <= setting_i[3:0];
            dead <= setting_i[6:0];
            period <= period_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            duty <= 10'h000;
        end else if (start_i || (duty_load_i && running)) begin
            duty <= duty_i;
        end
    end

    // Registered pins keep glitches off the FET drivers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_o <= 4'h0;
            pin_oe_n_o <= 4'hF;
            pwm_owned_o <= 4'h0;
            active_o <= 1'b0;
        end else begin
            pin_o <= next_pin;
            pin_oe_n_o <= next_oe_n;
            pwm_owned_o <= running ? owned : 4'h0;
            active_o <= running;
        end
    end
endmodule : bridge_pwm_controller

// *** include/bridge_pwm_pkg.sv ***
// Constants, mode and polarity codes for the bridge PWM controller.
// Assumes a single 20 MHz core clock.
package bridge_pwm_pkg;
    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_HALF = 2'h1,
        MODE_FULL_FWD = 2'h2,
        MODE_FULL_REV = 2'h3
    } mode_t;
    typedef enum logic [1:0] {
        polarity_all_high = 2'h0,
        polarity_ac_high_bd_low = 2'h1,
        polarity_ac_low_bd_high = 2'h2,
        polarity_all_low = 2'h3
    } polarity_t;
    // Run state, Gray coded along idle -> run
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1
    } run_state_t;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned OSC_PER_INSTR = 4;
    localparam logic [1:0] INSTR_DIV_MAX = 2'(OSC_PER_INSTR - 1);
    localparam int unsigned DUTY_W = 10;
    localparam int unsigned PERIOD_W = 8;
    localparam int unsigned DEAD_W = 7;
    localparam int unsigned OUT_N = 4;
    localparam logic [3:0] MASK_HALF = 4'h3;
    localparam logic [3:0] MASK_FULL = 4'hF;
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam int unsigned IDX_A = 0;
    localparam int unsigned IDX_B = 1;
    localparam int unsigned IDX_C = 2;
    localparam int unsigned IDX_D = 3;
endpackage : bridge_pwm_pkg

// *** include/dead_band_if.sv ***
// Carrier between the controller and its dead band stage.
// Assumes one clock; the controller drives raw, the stage returns gated.
`timescale 1ns/10ps
interface dead_band_if;
    logic raw;
    logic enable;
    logic tick;
    logic [6:0] delay;
    logic hi_ok;
    logic lo_ok;
    modport ctrl (output raw, output enable, output tick, output delay,
        input hi_ok, input lo_ok);
    modport stage (input raw, input enable, input tick, input delay,
        output hi_ok, output lo_ok);
endinterface : dead_band_if

// *** rtl/dead_band.sv ***
// Dead band stage: after each edge of the raw PWM, both sides stay
// inactive for at least the programmed count of instruction cycles.
// Assumes tick is a one-cycle enable every four core clocks.
`timescale 1ns/10ps
module dead_band (
    input wire logic core_clk_i, // Core clock
    input wire logic reset_n_i, // Async reset, active low
    dead_band_if.stage db // Raw PWM in, gated permits out
);
    logic raw_q;
    logic [7:0] count;
    logic [7:0] next_count;
    logic [7:0] reload;
    wire edge_seen = db.raw ^ raw_q;
    wire waiting = (count != 8'h00);

    // minimum dead time
    // The free divider may tick right after an edge, so a non-zero delay
    // loads one extra tick and never ends short of delay instruction cycles
    assign reload = (db.delay == 7'h00) ? 8'h00
                                        : {1'b0, db.delay} + 8'h01;

    always_comb begin
        next_count = count;
        if (!db.enable) begin
            next_count = 8'h00;
        end else if (edge_seen) begin
            next_count = reload;
        end else if (waiting && db.tick) begin
            next_count = count - 8'h01;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            raw_q <= 1'b0;
            count <= 8'h00;
        end else begin
            raw_q <= db.raw;
            count <= next_count;
        end
    end

    assign db.hi_ok = db.raw && !edge_seen && !waiting;
    assign db.lo_ok = !db.raw && !edge_seen && !waiting;
endmodule : dead_band

// *** sim/bridge_pwm_assertions.sv ***
// Checker on the controller's ports.
// Assumes bind from the testbench; mode is latched here at each start.
`timescale 1ns/10ps
module bridge_pwm_assertions (
    input wire logic core_clk_i, // Core clock
    input wire logic reset_n_i, // Async reset, active low
    input wire logic start_i, // Start strobe
    input wire logic stop_i, // Off strobe
    input wire logic [1:0] mode_i, // Mode code
    input wire logic [1:0] polarity_i, // Polarity code
    input wire logic [7:0] setting_i, // Mask or dead band
    input wire logic [3:0] gpio_oe_n_i, // General enables
    input wire logic [3:0] pin_o, // Pin levels
    input wire logic [3:0] pin_oe_n_o, // Pin enables
    input wire logic [3:0] pwm_owned_o, // Pins held
    input wire logic active_o // Running
);
    logic [1:0] mode_q;
    logic [1:0] pol_q;
    logic [3:0] mask_q;
    logic [1:0] since;
    wire [3:0] act = pin_o ^ {pol_q[0], pol_q[1], pol_q[0], pol_q[1]};
    // Outputs lag a start by two registers, so judge from the fourth cycle
    wire settled = active_o && (since == 2'h3);
    wire [3:0] own = (mode_q == 2'h0) ? mask_q :
        (mode_q == 2'h1) ? bridge_pwm_pkg::MASK_HALF :
        bridge_pwm_pkg::MASK_FULL;
    wire [3:0] so = act & pwm_owned_o;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {mode_q, pol_q, mask_q, since} <= 10'h000;
        end else if (start_i || stop_i) begin
            since <= 2'h0;
            if (start_i) begin
                {mode_q, pol_q, mask_q} <= {mode_i, polarity_i, setting_i[3:0]};
            end
        end else if (since != 2'h3) begin
            since <= since + 2'h1;
        end
    end
    a_owned_driven: assert property (
        (pwm_owned_o & pin_oe_n_o) == 4'h0)
        else $error("owned pin not driven");
    // Pins still show their reset enables on the first edge after release
    a_gpio_passes: assert property ($past(reset_n_i) &&
        $stable(gpio_oe_n_i) && $stable(pwm_owned_o) |->
        ((pin_oe_n_o ^ gpio_oe_n_i) & ~pwm_owned_o) == 4'h0)
        else $error("free pin not following gpio");
    a_mode_owns: assert property (settled |-> pwm_owned_o == own)
        else $error("wrong pins held");
    a_half_apart: assert property (settled && mode_q == 2'h1 |->
        !(act[0] && act[1])) else $error("half sides overlap");
    a_fwd_steer: assert property (settled && mode_q == 2'h2 |->
        act[0] && !act[1] && !act[2]) else $error("forward steering");
    a_rev_steer: assert property (settled && mode_q == 2'h3 |->
        act[2] && !act[0] && !act[3]) else $error("reverse steering");
    a_single_same: assert property (settled && mode_q == 2'h0 |->
        so == 4'h0 || so == pwm_owned_o) else $error("single outputs differ");
    a_start_runs: assert property (start_i && !stop_i && !active_o |->
        ##2 active_o) else $error("start did not activate");
    a_stop_frees: assert property (stop_i && !start_i && active_o |->
        ##[1:3] (!active_o && pwm_owned_o == 4'h0)) else $error("off failed");
    c_half: cover property (settled && mode_q == 2'h1);
    c_rev: cover property (settled && mode_q == 2'h3);
    c_stop: cover property (stop_i && active_o);
endmodule : bridge_pwm_assertions

// *** sim/bridge_driver_model.sv ***
// FET driver inputs: pull-down on each line, half bridge overlap watch.
// Assumes active-high drive when the overlap flag is read.
`timescale 1ns/10ps
module bridge_driver_model (
    input wire logic [3:0] pin_i, // Levels from the block
    input wire logic [3:0] oe_n_i, // Enables, low = drive
    output logic [3:0] lvl_o, // Resolved line levels
    output logic shoot_o // Both half sides on
);
    // Released lines fall to the pull-down, not the last value
    assign lvl_o = pin_i & ~oe_n_i;
    // high and low side on together
    assign shoot_o = lvl_o[0] & lvl_o[1];
endmodule : bridge_driver_model

// *** sim/testbench.sv ***
// Testbench: table of set-ups, then half bridge, duty update and off.
// Assumes the checker and driver model are compiled first.
`timescale 1ns/10ps
module testbench;
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] pol;
        logic [7:0] set;
        logic [7:0] per;
        logic [9:0] duty;
        logic [3:0] own;
        logic [31:0] cnt;
    } row_t;
    logic core_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic start_i = 1'b0;
    logic stop_i = 1'b0;
    logic duty_load_i = 1'b0;
    logic [1:0] mode_i = 2'h0;
    logic [1:0] polarity_i = 2'h0;
    logic [7:0] setting_i = 8'h00;
    logic [7:0] period_i = 8'h00;
    logic [9:0] duty_i = 10'h000;
    logic [3:0] gpio_out_i = 4'hA;
    logic [3:0] gpio_oe_n_i = 4'h5;
    logic [3:0] pin_o, pin_oe_n_o, pwm_owned_o, lvl;
    logic active_o, shoot;
    logic [31:0] cnt;
    int error_cnt = 0;
    int samples_checked = 0;
    int shoots;
    // full mode rows give a zero setting
    row_t rows [6] = '{
        '{2'h0, 2'h0, 8'h0F, 8'h09, 10'h004, 4'hF, 32'h04040404},
        '{2'h0, 2'h1, 8'h05, 8'h09, 10'h003, 4'h5, 32'h00030003},
        '{2'h0, 2'h1, 8'h0A, 8'h09, 10'h003, 4'hA, 32'h03000300},
        '{2'h2, 2'h2, 8'h00, 8'h09, 10'h006, 4'hF, 32'h0600000A},
        '{2'h3, 2'h3, 8'h00, 8'h07, 10'h014, 4'hF, 32'h00080800},
        '{2'h0, 2'h2, 8'h00, 8'h09, 10'h004, 4'h0, 32'h00000000}};
    bridge_pwm_controller u_bridge_pwm_controller (.core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i), .start_i(start_i), .stop_i(stop_i),
        .duty_load_i(duty_load_i), .mode_i(mode_i), .polarity_i(polarity_i),
        .setting_i(setting_i), .period_i(period_i), .duty_i(duty_i),
        .gpio_out_i(gpio_out_i), .gpio_oe_n_i(gpio_oe_n_i), .pin_o(pin_o),
        .pin_oe_n_o(pin_oe_n_o), .pwm_owned_o(pwm_owned_o),
        .active_o(active_o));
    bridge_driver_model u_bridge_driver_model (.pin_i(pin_o),
        .oe_n_i(pin_oe_n_o), .lvl_o(lvl), .shoot_o(shoot));
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    task automatic print_verdict();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : check
    task automatic strobe(input logic is_stop);
        @(posedge core_clk_i);
        if (is_stop) stop_i <= 1'b1;
        else start_i <= 1'b1;
        @(posedge core_clk_i);
        {start_i, stop_i} <= 2'h0;
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask : strobe
    task automatic go(input row_t r);
        @(posedge core_clk_i);
        {mode_i, polarity_i, setting_i} <= {r.mode, r.pol, r.set};
        {period_i, duty_i} <= {r.per, r.duty};
        strobe(1'b0);
    endtask : go
    // Counts active cycles of held pins only
    task automatic measure(input int n);
        logic [3:0] inv;
        inv = {polarity_i[0], polarity_i[1], polarity_i[0], polarity_i[1]};
        cnt = 32'h0;
        shoots = 0;
        repeat (n) begin
            @(negedge core_clk_i);
            for (int i = 0; i < 4; i++)
                cnt[8*i +: 8] += 8'(pwm_owned_o[i] & (lvl[i] ^ inv[i]));
            shoots += int'(shoot);
        end
    endtask : measure
    initial begin
        repeat (6) @(posedge core_clk_i);
        check(pin_oe_n_o === 4'hF && pwm_owned_o === 4'h0, "reset");
        reset_n_i <= 1'b1;
        foreach (rows[k]) begin
            go(rows[k]);
            check(pwm_owned_o === rows[k].own, "owned");
            check((pin_oe_n_o & rows[k].own) === 4'h0, "driven");
            check((((pin_oe_n_o ^ gpio_oe_n_i) | (pin_o ^ gpio_out_i))
                & ~rows[k].own) === 4'h0, "gpio kept");
            measure(int'(rows[k].per) + 1);
            check(cnt === rows[k].cnt,
                "counts");
            // off before any change of direction
            strobe(1'b1);
            check(!active_o && pwm_owned_o === 4'h0, "off");
        end
        // Dead time of 2 instruction cycles: 10 to 13 clocks blocked per edge
        go('{2'h1, 2'h0, 8'h02, 8'h27, 10'h014, 4'h3, 32'h0});
        measure(40);
        check(cnt[7:0] inside {[7:10]}, "A dead band");
        check(cnt[15:8] inside {[7:10]}, "B dead band");
        check(shoots === 0, "overlap");
        go(rows[0]);
        @(posedge core_clk_i);
        {duty_i, duty_load_i} <= {10'h007, 1'b1};
        @(posedge core_clk_i);
        duty_load_i <= 1'b0;
        measure(20);
        measure(10);
        check(cnt === 32'h07070707, "duty update");
        strobe(1'b1);
        check(pin_o === gpio_out_i && pin_oe_n_o === gpio_oe_n_i,
            "free");
        @(posedge core_clk_i);
        {gpio_out_i, gpio_oe_n_i} <= {4'h5, 4'hA};
        repeat (2) @(posedge core_clk_i);
        @(negedge core_clk_i);
        check(pin_o === 4'h5 && pin_oe_n_o === 4'hA, "gpio follow");
        print_verdict();
    end
    initial begin
        #50us;
        error_cnt++;
        print_verdict();
    end
endmodule : testbench
bind bridge_pwm_controller bridge_pwm_assertions u_bridge_pwm_assertions (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .start_i(start_i),
    .stop_i(stop_i), .mode_i(mode_i), .polarity_i(polarity_i),
    .setting_i(setting_i), .gpio_oe_n_i(gpio_oe_n_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .pwm_owned_o(pwm_owned_o), .active_o(active_o));
